// file: src/fei_defines.svh
// constants for the fp exception interrupt block
`ifndef FEI_DEFINES_SVH
`define FEI_DEFINES_SVH
`define FEI_W 32
`define FEI_INVALID_OP_BIT 0
`define FEI_DIV_ZERO_BIT 1
`define FEI_OVERFLOW_BIT 2
`define FEI_UNDERFLOW_BIT 3
`define FEI_INEXACT_BIT 4
`define FEI_IN_DENORMAL_BIT 7
`define FEI_FLAG_MASK 32'h0000009F
`define FEI_IRQ_MASK 32'h0000008F
`define FEI_LAZY_EN_BIT 30
`define FEI_AUTO_EN_BIT 31
`define FEI_MODE_LAZY_BIT 0
`define FEI_MODE_AUTO_BIT 1
`define FEI_MODE_NONE 2'h0
`define FEI_ISTAT_SERVICED 0
`define FEI_ISTAT_SAVED 1
`define FEI_RST_STATUS 32'h00000000
`define FEI_OFS_CTRL 5'h00
`define FEI_OFS_STATUS 5'h04
`define FEI_OFS_FLAGS 5'h08
`define FEI_OFS_STACK 5'h0C
`define FEI_OFS_ISTAT 5'h10
`define FEI_OFS_IMASK 5'h14
`endif

// file: src/fei_pkg.sv
// types for the fp exception interrupt block
package fei_pkg;
    typedef enum logic [3:0] {
        FEI_IDLE = 4'h1,
        FEI_RD = 4'h2,
        FEI_WR = 4'h4,
        FEI_DONE = 4'h8
    } fei_hstate_t;
endpackage

// file: src/fei_if.sv
// link between the flag unit and its handler end
`timescale 1ns/10ps
interface fei_if;
    logic sr_rd;
    logic sr_wr;
    logic [31:0] sr_wdata;
    logic [31:0] sr_rdata;
    logic [31:0] stack_copy;
    logic stack_valid;
    logic irq;
    logic [1:0] preserve_mode;
    modport dev (input sr_rd, input sr_wr, input sr_wdata, input preserve_mode,
        output sr_rdata, output stack_copy, output stack_valid, output irq);
    modport hst (output sr_rd, output sr_wr, output sr_wdata, output preserve_mode,
        input sr_rdata, input stack_copy, input stack_valid, input irq);
endinterface

// file: src/fei_dev.sv
// floating-point exception flags and combined interrupt request
`timescale 1ns/10ps
`include "fei_defines.svh"
module fei_dev (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // exception events from the datapath, one pulse bit per flag
    input wire logic [7:0] EXC_EVENT_I,
    // link to the handler
    fei_if.dev LINK
);
    typedef struct packed {
        logic [31:0] sr;
        logic [31:0] stk;
        logic stk_v;
        logic [31:0] rdata;
        logic irq;
    } fei_dev_state_t;
    fei_dev_state_t s_q, s_d;
    logic [31:0] ev;
    logic lazy;
    logic auto_on;

    assign ev = {24'h000000, EXC_EVENT_I} & `FEI_FLAG_MASK;
    assign lazy = LINK.preserve_mode[`FEI_MODE_LAZY_BIT];
    assign auto_on = LINK.preserve_mode[`FEI_MODE_AUTO_BIT];

    always_comb begin
        s_d = s_q;
        s_d.stk_v = 1'b0;
        if (LINK.sr_wr) begin
            s_d.sr = LINK.sr_wdata;
        end
        if (LINK.sr_rd) begin
            s_d.rdata = s_q.sr;
            if (lazy) begin
                s_d.stk = s_q.sr;
                s_d.stk_v = 1'b1;
                s_d.sr = s_q.sr & ~`FEI_FLAG_MASK;
            end else if (auto_on) begin
                s_d.sr = s_q.sr & ~`FEI_FLAG_MASK;
            end
        end
        // new events win over a clear in the same cycle
        s_d.sr = s_d.sr | ev;
        // level or of five flags, inexact left out, no mask here
        s_d.irq = |(s_d.sr & `FEI_IRQ_MASK);
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign LINK.sr_rdata = s_q.rdata;
    assign LINK.stack_copy = s_q.stk;
    assign LINK.stack_valid = s_q.stk_v;
    assign LINK.irq = s_q.irq;
endmodule // fei_dev

// file: src/fei_host.sv
// handler end: service the request, clear flags per preservation mode
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "fei_defines.svh"
module fei_host (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // avalon-mm slave
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // interrupt to the system
    output logic IRQ_O,
    // link to the flag unit
    fei_if.hst LINK
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] last;
        logic [31:0] stk;
        logic [1:0] istat;
        logic [1:0] imask;
        fei_pkg::fei_hstate_t phase;
        logic rd;
        logic wr;
        logic [31:0] wd;
        logic [31:0] rdata;
        logic wait_n;
        logic irq;
    } fei_host_state_t;
    fei_host_state_t s_q, s_d;
    logic acc;
    logic [1:0] mode;
    logic taking;
    logic [1:0] hev;
    logic [1:0] wbits;

    assign acc = (AVS_READ_I | AVS_WRITE_I) & ~s_q.wait_n;
    assign mode = {s_q.ctrl[`FEI_AUTO_EN_BIT], s_q.ctrl[`FEI_LAZY_EN_BIT]};
    // status copy lags the read strobe by a cycle: take it once the strobe is gone
    assign taking = (s_q.phase == fei_pkg::FEI_RD) & ~s_q.rd;
    assign hev[`FEI_ISTAT_SERVICED] = taking;
    assign hev[`FEI_ISTAT_SAVED] = LINK.stack_valid;
    assign wbits = AVS_WRITEDATA_I[`FEI_ISTAT_SAVED:`FEI_ISTAT_SERVICED];

    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        s_d.wr = 1'b0;
        s_d.wait_n = 1'b0;
        case (s_q.phase)
            fei_pkg::FEI_IDLE: begin
                if (LINK.irq) begin
                    s_d.rd = 1'b1;
                    s_d.phase = fei_pkg::FEI_RD;
                end
            end
            fei_pkg::FEI_RD: begin
                if (taking) begin
                    s_d.last = LINK.sr_rdata;
                    if (mode == `FEI_MODE_NONE) begin
                        s_d.wr = 1'b1;
                        s_d.wd = LINK.sr_rdata & ~`FEI_IRQ_MASK;
                        s_d.phase = fei_pkg::FEI_WR;
                    end else begin
                        s_d.phase = fei_pkg::FEI_DONE;
                    end
                end
            end
            fei_pkg::FEI_WR: begin
                s_d.phase = fei_pkg::FEI_DONE;
            end
            // gives the cleared level time to reach irq before idle looks again
            fei_pkg::FEI_DONE: begin
                s_d.phase = fei_pkg::FEI_IDLE;
            end
            default: begin
                s_d.phase = fei_pkg::FEI_IDLE;
            end
        endcase
        if (LINK.stack_valid) begin
            s_d.stk = LINK.stack_copy & ~`FEI_IRQ_MASK;
        end
        if (acc) begin
            s_d.wait_n = 1'b1;
            s_d.rdata = 32'h00000000;
            if (AVS_WRITE_I) begin
                case (AVS_ADDRESS_I)
                    `FEI_OFS_CTRL: s_d.ctrl = AVS_WRITEDATA_I;
                    `FEI_OFS_ISTAT: s_d.istat = s_q.istat & ~wbits;
                    `FEI_OFS_IMASK: s_d.imask = wbits;
                    default: s_d.rdata = 32'h00000000;
                endcase
            end else begin
                case (AVS_ADDRESS_I)
                    `FEI_OFS_CTRL: s_d.rdata = s_q.ctrl;
                    `FEI_OFS_STATUS: s_d.rdata = {28'h0000000, s_q.phase};
                    `FEI_OFS_FLAGS: s_d.rdata = s_q.last;
                    `FEI_OFS_STACK: s_d.rdata = s_q.stk;
                    `FEI_OFS_ISTAT: s_d.rdata = {30'h0, s_q.istat};
                    `FEI_OFS_IMASK: s_d.rdata = {30'h0, s_q.imask};
                    default: s_d.rdata = 32'h00000000;
                endcase
            end
        end
        // set wins over a same-cycle clear
        s_d.istat = s_d.istat | hev;
        s_d.irq = |(s_d.istat & s_d.imask);
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            s_q <= '{phase: fei_pkg::FEI_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign LINK.sr_rd = s_q.rd;
    assign LINK.sr_wr = s_q.wr;
    assign LINK.sr_wdata = s_q.wd;
    assign LINK.preserve_mode = mode;
    assign AVS_READDATA_O = s_q.rdata;
    assign AVS_WAITREQUEST_O = ~s_q.wait_n;
    assign IRQ_O = s_q.irq;
endmodule // fei_host

// file: tb/fei_assertions.sv
// concurrent checks on the flag unit link
`timescale 1ns/10ps
module fei_assertions (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // watched signals
    input wire logic [7:0] EXC_EVENT_I,
    input wire logic sr_rd,
    input wire logic sr_wr,
    input wire logic [31:0] sr_wdata,
    input wire logic stack_valid,
    input wire logic irq,
    input wire logic [1:0] preserve_mode
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // inexact left out on purpose
    wire logic ev = |(EXC_EVENT_I & 8'h8F);
    sequence s_lazy_rd;
        sr_rd && preserve_mode[0] && !ev;
    endsequence
    a_event_raises_irq: assert property (ev |=> irq) else $error("irq missed");
    a_inexact_is_quiet: assert property (!irq && EXC_EVENT_I == 8'h10 |=> !irq)
        else $error("inexact raised irq");
    a_irq_stays_set: assert property (irq && !sr_wr && !sr_rd |=> irq)
        else $error("irq dropped");
    a_zero_write_clears: assert property (
        sr_wr && (sr_wdata & 32'h8F) == 32'h0 && !ev |=> !irq) else $error("write left irq");
    a_plain_read_keeps: assert property (sr_rd && preserve_mode == 2'h0 && irq |=> irq)
        else $error("read cleared flags");
    a_lazy_read_clears: assert property (s_lazy_rd |=> !irq) else $error("lazy kept");
    a_lazy_read_saves: assert property (s_lazy_rd |-> ##[1:2] stack_valid)
        else $error("no stack save");
    a_auto_read_clears: assert property (sr_rd && preserve_mode == 2'h2 && !ev |=> !irq)
        else $error("auto kept");
    a_clear_mask_used: assert property (sr_wr |-> (sr_wdata & 32'h8F) == 32'h0)
        else $error("flags not masked");
endmodule // fei_assertions

// file: tb/fpu_exception_irq_logic_tb.sv
// bench for the fp exception interrupt block
`timescale 1ns/10ps
module fpu_exception_irq_logic_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] ev = 8'h00;
    logic [4:0] adr = 5'h00;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdq;
    logic wrq;
    logic irq;
    logic [31:0] q;
    logic [7:0] fl [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
    logic [31:0] md [3] = '{32'h40000000, 32'hC0000000, 32'h80000000};
    logic [31:0] ex [3] = '{32'h3, 32'h3, 32'h1};
    // inexact survives the clear mask on the first save only
    logic [31:0] sk [3] = '{32'h10, 32'h0, 32'h0};
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    fei_if i_fei_if ();
    fei_dev i_fei_dev (.CLOCK_I(clk), .RST_N_I(rst_n), .EXC_EVENT_I(ev), .LINK(i_fei_if));
    fei_host i_fei_host (.CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdq),
        .AVS_WAITREQUEST_O(wrq), .IRQ_O(irq), .LINK(i_fei_if));
    fei_assertions i_fei_assertions (.CLOCK_I(clk), .RST_N_I(rst_n), .EXC_EVENT_I(ev),
        .sr_rd(i_fei_if.sr_rd), .sr_wr(i_fei_if.sr_wr), .sr_wdata(i_fei_if.sr_wdata),
        .stack_valid(i_fei_if.stack_valid), .irq(i_fei_if.irq),
        .preserve_mode(i_fei_if.preserve_mode));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do @(posedge clk); while (wrq !== 1'h0);
        q = rdq;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    // bounded poll, so a lost event ends with q[0] low
    task automatic svc(input logic [7:0] m);
        int n;
        n = 0;
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        do begin
            bus(1'h0, 5'h10, 32'h0);
            n++;
        end while (q[0] !== 1'h1 && n < 20);
        @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        bus(1'h1, 5'h14, 32'h1);
        foreach (fl[i]) begin
            svc(fl[i]);
            chk({31'h0, irq}, 32'h1);
            chk({31'h0, i_fei_if.irq}, 32'h0);
            bus(1'h0, 5'h08, 32'h0);
            chk(q, {24'h0, fl[i]});
            bus(1'h1, 5'h10, 32'h1);
            @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        bus(1'h1, 5'h14, 32'h0);
        svc(8'h01);
        chk({q[0], irq}, 32'h2);
        bus(1'h1, 5'h10, 32'h1);
        svc(8'h10);
        chk(q, 32'h0);
        foreach (md[i]) begin
            bus(1'h1, 5'h00, md[i]);
            svc(8'h02);
            chk({31'h0, i_fei_if.irq}, 32'h0);
            bus(1'h0, 5'h10, 32'h0);
            chk(q, ex[i]);
            bus(1'h0, 5'h0C, 32'h0);
            chk(q, sk[i]);
            bus(1'h0, 5'h00, 32'h0);
            chk(q, md[i]);
            bus(1'h1, 5'h10, 32'h3);
        end
        bus(1'h0, 5'h18, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, 5'h04, 32'h0);
        chk(q, {28'h0, fei_pkg::FEI_IDLE});
        print_verdict();
    end
endmodule // fpu_exception_irq_logic_tb
